// ---- hdl/instruction_exception_detector.v ----
// Functional notes
// RQ1: trap instruction raises software trap to general handler.
// RQ2: break instruction goes to break handler, not general exception.
// RQ3: valid but unimplemented instruction raises unimplemented exception.
// RQ4: undefined opcode raises illegal exception when checking on; forced with MMU/MPU.
// RQ5: internally used undefined encodings never raise illegal exception.
// RQ6: user mode with MMU/MPU: supervisor-only instructions raise exception.
// RQ7: MMU user mode fetch from supervisor range raises exception.
// RQ8: MMU user mode load/store/flush to supervisor data raises exception.
// RQ9: misaligned data check forced with MMU/MPU, optional otherwise.
// RQ10: word needs address multiple of four, half of two; bytes always aligned.
// RQ11: control-transfer target check forced with MMU/MPU, optional otherwise.
// RQ12: transfer target misaligned unless multiple of four.
// RQ13: divide by zero or most-negative by minus one raises division error.
// RQ14: TLB miss with exception flag clear sets it, vectors to fast handler.
// RQ15: miss from fetch or data access; data miss is recorded.
// RQ16: TLB miss with exception flag set is double miss to general handler.
// RQ17: TLB permission refusal raises violation reporting execute, read or write.
// RQ18: data-cache init and flush bypass TLB permission checks.
// RQ19: MPU no-match or forbidden region raises region violation.
// RQ20: MPU violation classed instruction or data in cause.
// RQ21: checks of absent units or disabled options tied inactive.
// RQ22: coinciding conditions report exactly one by fixed priority.
`timescale 1ns/1ns
`default_nettype none
`include "exc_defs.vh"

module instruction_exception_detector #(
  parameter HAS_MMU = 0,
  parameter HAS_MPU = 0,
  parameter HAS_HW_DIV = 1,
  parameter OPT_ILLEGAL_CHECK = 1,
  parameter OPT_MISALIGN_DATA = 1,
  parameter OPT_MISALIGN_DST = 1,
  parameter OPT_DIV_ERR = 1
) (
  input wire core_clk,
  input wire reset_n,
  // decode stage classification
  input wire insn_valid,
  input wire is_trap,
  input wire is_break,
  input wire is_unimpl,
  input wire is_undefined,
  input wire is_internal_enc,
  input wire is_supv_only,
  input wire user_mode,
  input wire exception_active_flag,
  // fetch side translation/protection
  input wire fetch_valid,
  input wire fetch_supv_addr,
  input wire fetch_tlb_miss,
  input wire fetch_tlb_no_exec,
  input wire fetch_mpu_fault,
  // data side
  input wire is_load,
  input wire is_store,
  input wire is_dcache_init,
  input wire is_dcache_flush_addr,
  input wire is_dcache_line_op,
  input wire [31:0] data_addr,
  input wire [1:0] data_size,
  input wire data_supv_addr,
  input wire data_tlb_miss,
  input wire data_tlb_no_read,
  input wire data_tlb_no_write,
  input wire data_mpu_fault,
  // control transfers
  input wire is_xfer,
  input wire [31:0] xfer_target,
  // divide
  input wire is_div,
  input wire div_signed,
  input wire [31:0] div_dividend,
  input wire [31:0] div_divisor,
  // report to exception entry
  output reg exc_valid,
  output reg [4:0] exc_kind,
  output reg [1:0] exc_vector,
  output reg miss_is_data,
  output reg set_exception_active,
  output reg keep_saved_state
);
  localparam PROT = (HAS_MMU != 0) || (HAS_MPU != 0);
  localparam EN_ILL = PROT || (OPT_ILLEGAL_CHECK != 0); // RQ4
  localparam EN_MAD = PROT || (OPT_MISALIGN_DATA != 0); // RQ9
  localparam EN_MDST = PROT || (OPT_MISALIGN_DST != 0); // RQ11
  localparam EN_DIV = (HAS_HW_DIV != 0) && (OPT_DIV_ERR != 0); // RQ21
  localparam EN_MMU = (HAS_MMU != 0);
  localparam EN_MPU = (HAS_MPU != 0);

  wire data_access;
  wire data_misaligned;
  wire div_fault;
  wire dst_bad;
  wire c_illegal;
  wire c_supv_insn;
  wire c_supv_i;
  wire c_supv_d;
  wire c_mad;
  wire c_mdst;
  wire c_div;
  wire c_miss_i;
  wire c_miss_d;
  wire c_perm_x;
  wire c_perm_r;
  wire c_perm_w;
  wire c_mpu_i;
  wire c_mpu_d;
  wire data_xlate;
  reg hit;
  reg [4:0] kind;
  reg [1:0] vec;
  reg miss_d;

  assign data_access = is_load || is_store;
  assign data_xlate = data_access || is_dcache_init || is_dcache_flush_addr; // RQ15

  align_check u_align (
    .addr_lo(data_addr[1:0]),
    .size(data_size),
    .misaligned(data_misaligned)
  );

  div_check u_div (
    .dividend(div_dividend),
    .divisor(div_divisor),
    .is_signed(div_signed),
    .div_err(div_fault)
  );

  assign dst_bad = (xfer_target[1:0] != 2'h0); // RQ12

  // option and unit gating keeps absent checks silent
  assign c_illegal = EN_ILL && is_undefined && !is_internal_enc; // RQ4 RQ5 RQ21
  assign c_supv_insn = PROT && user_mode && is_supv_only; // RQ6 RQ21
  assign c_supv_i = EN_MMU && user_mode && fetch_valid && fetch_supv_addr; // RQ7 RQ21
  assign c_supv_d = EN_MMU && user_mode && (data_access || is_dcache_flush_addr) &&
                    data_supv_addr; // RQ8 RQ21
  assign c_mad = EN_MAD && data_access && data_misaligned; // RQ9 RQ21
  assign c_mdst = EN_MDST && is_xfer && dst_bad; // RQ11 RQ21
  assign c_div = EN_DIV && is_div && div_fault; // RQ13 RQ21
  assign c_miss_i = EN_MMU && fetch_valid && fetch_tlb_miss; // RQ15 RQ21
  assign c_miss_d = EN_MMU && data_xlate && data_tlb_miss; // RQ15 RQ21
  // cache maintenance ignores permissions
  assign c_perm_x = EN_MMU && fetch_valid && !fetch_tlb_miss && fetch_tlb_no_exec; // RQ17
  assign c_perm_r = EN_MMU && is_load && !is_dcache_line_op && !data_tlb_miss &&
                    data_tlb_no_read; // RQ17 RQ18
  assign c_perm_w = EN_MMU && is_store && !is_dcache_line_op && !data_tlb_miss &&
                    data_tlb_no_write; // RQ17 RQ18
  assign c_mpu_i = EN_MPU && fetch_valid && fetch_mpu_fault; // RQ19 RQ20 RQ21
  assign c_mpu_d = EN_MPU && data_xlate && data_mpu_fault; // RQ19 RQ20 RQ21

  // fetch faults first, then decode, then execute, then data faults
  always @* begin
    hit = 1'b1;
    kind = `EXC_NONE;
    vec = `VEC_GENERAL;
    miss_d = 1'b0;
    if (c_miss_i) begin // RQ22
      if (exception_active_flag) begin
        kind = `EXC_DBL_TLB_I; // RQ16
      end else begin
        kind = `EXC_FAST_TLB_I; // RQ14
        vec = `VEC_FAST;
      end
    end else if (c_supv_i) begin
      kind = `EXC_SUPV_IADDR; // RQ7
    end else if (c_perm_x) begin
      kind = `EXC_TLB_PERM_X; // RQ17
    end else if (c_mpu_i) begin
      kind = `EXC_MPU_I; // RQ20
    end else if (!insn_valid) begin
      hit = 1'b0;
      vec = `VEC_NONE;
    end else if (is_break) begin
      kind = `EXC_BREAK; // RQ2
      vec = `VEC_BREAK;
    end else if (is_trap) begin
      kind = `EXC_TRAP; // RQ1
    end else if (c_illegal) begin
      kind = `EXC_ILLEGAL; // RQ4
    end else if (is_unimpl) begin
      kind = `EXC_UNIMPL; // RQ3
    end else if (c_supv_insn) begin
      kind = `EXC_SUPV_INSN; // RQ6
    end else if (c_div) begin
      kind = `EXC_DIV_ERR; // RQ13
    end else if (c_mdst) begin
      kind = `EXC_MISALIGN_DST; // RQ11
    end else if (c_mad) begin
      kind = `EXC_MISALIGN_D; // RQ9
    end else if (c_miss_d) begin
      miss_d = 1'b1; // RQ15
      if (exception_active_flag) begin
        kind = `EXC_DBL_TLB_D; // RQ16
      end else begin
        kind = `EXC_FAST_TLB_D; // RQ14
        vec = `VEC_FAST;
      end
    end else if (c_supv_d) begin
      kind = `EXC_SUPV_DADDR; // RQ8
    end else if (c_perm_r) begin
      kind = `EXC_TLB_PERM_R; // RQ17
    end else if (c_perm_w) begin
      kind = `EXC_TLB_PERM_W; // RQ17
    end else if (c_mpu_d) begin
      kind = `EXC_MPU_D; // RQ20
    end else begin
      hit = 1'b0;
      vec = `VEC_NONE;
    end
  end

  // one registered report per cycle; entry logic sees a clean pulse
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      exc_valid <= 1'b0;
      exc_kind <= `EXC_NONE;
      exc_vector <= `VEC_NONE;
      miss_is_data <= 1'b0;
      set_exception_active <= 1'b0;
      keep_saved_state <= 1'b0;
    end else begin
      exc_valid <= hit; // RQ22
      exc_kind <= kind;
      exc_vector <= vec;
      if (hit && ((kind == `EXC_FAST_TLB_I) || (kind == `EXC_FAST_TLB_D) ||
                  (kind == `EXC_DBL_TLB_I) || (kind == `EXC_DBL_TLB_D))) begin
        miss_is_data <= miss_d; // RQ15
      end
      set_exception_active <= hit && (vec == `VEC_FAST); // RQ14
      keep_saved_state <= hit && ((kind == `EXC_DBL_TLB_I) ||
                                  (kind == `EXC_DBL_TLB_D)); // RQ16
    end
  end
endmodule // instruction_exception_detector

`default_nettype wire

// ---- hdl/exc_defs.vh ----
`ifndef EXC_DEFS_VH
`define EXC_DEFS_VH

// exception kind codes reported on exc_kind
`define EXC_NONE          5'h00
`define EXC_TRAP          5'h01
`define EXC_BREAK         5'h02
`define EXC_UNIMPL        5'h03
`define EXC_ILLEGAL       5'h04
`define EXC_SUPV_INSN     5'h05
`define EXC_SUPV_IADDR    5'h06
`define EXC_SUPV_DADDR    5'h07
`define EXC_MISALIGN_D    5'h08
`define EXC_MISALIGN_DST  5'h09
`define EXC_DIV_ERR       5'h0A
`define EXC_FAST_TLB_I    5'h0B
`define EXC_FAST_TLB_D    5'h0C
`define EXC_DBL_TLB_I     5'h0D
`define EXC_DBL_TLB_D     5'h0E
`define EXC_TLB_PERM_X    5'h0F
`define EXC_TLB_PERM_R    5'h10
`define EXC_TLB_PERM_W    5'h11
`define EXC_MPU_I         5'h12
`define EXC_MPU_D         5'h13

// handler vector select
`define VEC_NONE    2'h0
`define VEC_GENERAL 2'h1
`define VEC_FAST    2'h2
`define VEC_BREAK   2'h3

// access size codes
`define SIZE_BYTE 2'h0
`define SIZE_HALF 2'h1
`define SIZE_WORD 2'h2

// division error operands
`define DIV_MOST_NEG 32'h80000000
`define DIV_MINUS_1  32'hFFFFFFFF

`endif

// ---- hdl/align_check.v ----
`timescale 1ns/1ns
`default_nettype none
`include "exc_defs.vh"

module align_check (
  input wire [1:0] addr_lo,
  input wire [1:0] size,
  output wire misaligned
);
  // byte accesses never misalign
  assign misaligned = ((size == `SIZE_WORD) && (addr_lo != 2'h0)) || // RQ10
                      ((size == `SIZE_HALF) && addr_lo[0]); // RQ10
endmodule // align_check

`default_nettype wire

// ---- hdl/div_check.v ----
`timescale 1ns/1ns
`default_nettype none
`include "exc_defs.vh"

module div_check (
  input wire [31:0] dividend,
  input wire [31:0] divisor,
  input wire is_signed,
  output wire div_err
);
  assign div_err = (divisor == 32'h00000000) || // RQ13
                   (is_signed && (dividend == `DIV_MOST_NEG) &&
                    (divisor == `DIV_MINUS_1)); // RQ13
endmodule // div_check

`default_nettype wire

// ---- test/exc_detector_properties.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "exc_defs.vh"
module exc_detector_properties (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic insn_valid,
  input wire logic is_trap,
  input wire logic is_load,
  input wire logic is_div,
  input wire logic [31:0] div_divisor,
  input wire logic [1:0] data_size,
  input wire logic [31:0] data_addr,
  input wire logic fetch_valid,
  input wire logic fetch_tlb_miss,
  input wire logic exception_active_flag,
  input wire logic is_xfer,
  input wire logic [31:0] xfer_target,
  input wire logic exc_valid,
  input wire logic [4:0] exc_kind,
  input wire logic [1:0] exc_vector,
  input wire logic set_exception_active,
  input wire logic keep_saved_state
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);
  trap_vec_a: assert property (
    exc_kind == `EXC_TRAP |-> $past(is_trap) && exc_vector == `VEC_GENERAL)
    else $error("trap misreported");
  break_vec_a: assert property (
    exc_kind == `EXC_BREAK |-> exc_vector == `VEC_BREAK)
    else $error("break not on break vector");
  div_zero_a: assert property (
    insn_valid && is_div && div_divisor == 32'h0 |=> exc_valid)
    else $error("divide by zero missed");
  word_mis_a: assert property (
    insn_valid && is_load && data_size == `SIZE_WORD && data_addr[1:0] != 2'h0 |=> exc_valid)
    else $error("misaligned word missed");
  dst_mis_a: assert property (
    insn_valid && is_xfer && xfer_target[1:0] != 2'h0 |=> exc_valid)
    else $error("misaligned target missed");
  fast_miss_a: assert property (
    fetch_valid && fetch_tlb_miss && !exception_active_flag
    |=> exc_kind == `EXC_FAST_TLB_I && set_exception_active && exc_vector == `VEC_FAST)
    else $error("fast miss wrong");
  dbl_miss_a: assert property (
    fetch_valid && fetch_tlb_miss && exception_active_flag
    |=> keep_saved_state && !set_exception_active && exc_vector == `VEC_GENERAL)
    else $error("double miss wrong");
  one_report_a: assert property (
    exc_valid == (exc_kind != `EXC_NONE) && exc_valid == (exc_vector != `VEC_NONE))
    else $error("report fields disagree");
  mpu_off_a: assert property (
    exc_kind != `EXC_MPU_I && exc_kind != `EXC_MPU_D)
    else $error("absent protection unit fired");
  cover property (set_exception_active);
  cover property (keep_saved_state);
  cover property (exc_kind == `EXC_DIV_ERR);
endmodule // exc_detector_properties
`default_nettype wire

// ---- test/exc_entry_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module exc_entry_model (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic set_active,
  input wire logic clear_req,
  output logic active_q
);
  // a fresh fast miss wins over a clear so a handler exit never hides it
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n)
      active_q <= 1'b0;
    else if (set_active || clear_req)
      active_q <= set_active;
  end
endmodule // exc_entry_model
`default_nettype wire

// ---- test/tb.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "exc_defs.vh"
module tb;
  logic core_clk = 0;
  logic reset_n;
  logic [31:0] b = 0, a = 0, t = 0, dd = 0, dv = 0, r, seed = 32'hF707;
  logic exc_valid, miss_is_data, set_exception_active, keep_saved_state, flag_q, md_q = 0;
  logic [4:0] exc_kind, ek = 0;
  logic [1:0] exc_vector;
  logic [5:0] ef = 0;
  int failures = 0, samples_checked = 0;
  wire [2:0] op = b[24:22];
  wire ld = op == 3'h1;
  wire st = op == 3'h2;
  wire [1:0] sz = b[26:25] == 2'h3 ? `SIZE_WORD : b[26:25];
  instruction_exception_detector #(.HAS_MMU(1)) dut_u (.core_clk(core_clk), .reset_n(reset_n),
    .insn_valid(b[0]), .is_trap(b[1]), .is_break(b[2]), .is_unimpl(b[3]), .is_undefined(b[4]),
    .is_internal_enc(b[5]), .is_supv_only(b[6]), .user_mode(b[7]),
    .exception_active_flag(flag_q), .fetch_valid(b[8]), .fetch_supv_addr(b[9]),
    .fetch_tlb_miss(b[10]), .fetch_tlb_no_exec(b[11]), .fetch_mpu_fault(b[12]), .is_load(ld),
    .is_store(st), .is_dcache_init(op == 3'h3), .is_dcache_flush_addr(op == 3'h4),
    .is_dcache_line_op(op > 3'h2 && op < 3'h6), .data_addr(a), .data_size(sz),
    .data_supv_addr(b[13]), .data_tlb_miss(b[14]), .data_tlb_no_read(b[15]),
    .data_tlb_no_write(b[16]), .data_mpu_fault(b[17]), .is_xfer(b[18]), .xfer_target(t),
    .is_div(b[19]), .div_signed(b[20]), .div_dividend(dd), .div_divisor(dv),
    .exc_valid(exc_valid), .exc_kind(exc_kind), .exc_vector(exc_vector),
    .miss_is_data(miss_is_data), .set_exception_active(set_exception_active),
    .keep_saved_state(keep_saved_state));
  exc_entry_model pm_u (.core_clk(core_clk), .reset_n(reset_n),
    .set_active(set_exception_active), .clear_req(b[21]), .active_q(flag_q));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // decoded from b directly: the op wires lag a blocking update of b in this step
  function automatic logic [4:0] kind_of();
    logic mis, ld, st;
    logic [2:0] op;
    logic [1:0] sz;
    op = b[24:22];
    ld = op == 3'h1;
    st = op == 3'h2;
    sz = b[26:25] == 2'h3 ? `SIZE_WORD : b[26:25];
    mis = sz == `SIZE_WORD ? a[1:0] != 2'h0 : sz == `SIZE_HALF && a[0];
    if (b[8] && b[10]) return flag_q ? `EXC_DBL_TLB_I : `EXC_FAST_TLB_I;
    if (b[8] && b[7] && b[9]) return `EXC_SUPV_IADDR;
    if (b[8] && b[11]) return `EXC_TLB_PERM_X;
    if (!b[0]) return `EXC_NONE;
    if (b[2]) return `EXC_BREAK;
    if (b[1]) return `EXC_TRAP;
    if (b[4] && !b[5]) return `EXC_ILLEGAL;
    if (b[3]) return `EXC_UNIMPL;
    if (b[7] && b[6]) return `EXC_SUPV_INSN;
    if (b[19] && (dv == 32'h0 || b[20] && dd == `DIV_MOST_NEG && dv == `DIV_MINUS_1))
      return `EXC_DIV_ERR;
    if (b[18] && t[1:0] != 2'h0) return `EXC_MISALIGN_DST;
    if ((ld || st) && mis) return `EXC_MISALIGN_D;
    if (op != 3'h0 && op < 3'h5 && b[14]) return flag_q ? `EXC_DBL_TLB_D : `EXC_FAST_TLB_D;
    if (b[7] && b[13] && (ld || st || op == 3'h4)) return `EXC_SUPV_DADDR;
    if (ld && b[15]) return `EXC_TLB_PERM_R;
    if (st && b[16]) return `EXC_TLB_PERM_W;
    return `EXC_NONE;
  endfunction
  task automatic chk_kind(input logic [4:0] got, input logic [4:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_flags(input logic [5:0] got, input logic [5:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: %h expected %h", $time, got, exp);
    end
  endtask
  // outputs lag one edge, so each step checks the previous step's expectation
  task automatic step(input logic [31:0] nb, na, nt, ndd, ndv);
    logic fast, dbl;
    @(posedge core_clk);
    #1;
    chk_kind(exc_kind, ek);
    chk_flags({exc_valid, exc_vector, set_exception_active, keep_saved_state, miss_is_data}, ef);
    {b, a, t, dd, dv} = {nb, na, nt, ndd, ndv};
    ek = kind_of();
    fast = ek == `EXC_FAST_TLB_I || ek == `EXC_FAST_TLB_D;
    dbl = ek == `EXC_DBL_TLB_I || ek == `EXC_DBL_TLB_D;
    if (fast || dbl) md_q = ek == `EXC_FAST_TLB_D || ek == `EXC_DBL_TLB_D;
    ef = {ek != 5'h0, ek == `EXC_BREAK ? `VEC_BREAK : fast ? `VEC_FAST :
      ek != 5'h0 ? `VEC_GENERAL : `VEC_NONE, fast, dbl, md_q};
  endtask
  task automatic stop_test();
    if (failures == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  logic [31:0] cs[15] = '{32'h80001, 32'h3, 32'h7, 32'h11, 32'h31, 32'h9, 32'hC1, 32'h500,
    32'h0, 32'h500, 32'h404001, 32'h200000, 32'h404001, 32'h402081, 32'h21001};
  initial begin
    forever #20 core_clk = ~core_clk;
  end
  initial begin
    #400000;
    failures++;
    stop_test();
  end
  initial begin
    reset_n = 0;
    repeat (10) @(posedge core_clk);
    #1;
    reset_n = 1;
    step(32'h180001, 0, 0, `DIV_MOST_NEG, `DIV_MINUS_1);
    step(32'h80001, 0, 0, `DIV_MOST_NEG, `DIV_MINUS_1);
    for (int i = 0; i < 12; i++) step(32'h400001 | i >> 2 << 25, i, 0, 0, 1);
    for (int i = 0; i < 4; i++) step(32'h40001, 0, i, 0, 1);
    foreach (cs[i]) step(cs[i], 1, 0, 0, 1);
    step(32'h408001, 0, 0, 0, 1);
    step(32'h810001, 0, 0, 0, 1);
    step(32'hC18001, 0, 0, 0, 1);
    repeat (3000) begin
      r = rnd();
      step((rnd() & rnd() & rnd() & 32'hFFE7E) | (r & 32'h07F00181), rnd(), rnd(),
        r[1] ? `DIV_MOST_NEG : rnd(), r[2] ? 32'h0 : r[3] ? `DIV_MINUS_1 : rnd());
    end
    step(0, 0, 0, 0, 1);
    step(0, 0, 0, 0, 1);
    stop_test();
  end
endmodule // tb
bind instruction_exception_detector exc_detector_properties chk_u (.core_clk(core_clk),
  .reset_n(reset_n), .insn_valid(insn_valid), .is_trap(is_trap), .is_load(is_load),
  .is_div(is_div), .div_divisor(div_divisor), .data_size(data_size), .data_addr(data_addr),
  .fetch_valid(fetch_valid), .fetch_tlb_miss(fetch_tlb_miss),
  .exception_active_flag(exception_active_flag), .is_xfer(is_xfer),
  .xfer_target(xfer_target), .exc_valid(exc_valid), .exc_kind(exc_kind),
  .exc_vector(exc_vector), .set_exception_active(set_exception_active),
  .keep_saved_state(keep_saved_state));
`default_nettype wire
